// ---- exec_pkg.sv ----
// Package: opcodes, timing and layout constants for the branch/move execution unit
package exec_pkg;

    // ------------------------------------------------------------
    // Opcodes (single values)
    // ------------------------------------------------------------
    localparam logic [7:0] OP_JMP_IND      = 8'h73;
    localparam logic [7:0] OP_BR_BIT_CLR   = 8'h30;
    localparam logic [7:0] OP_BR_CY_CLR    = 8'h50;
    localparam logic [7:0] OP_BR_NONZERO   = 8'h70;
    localparam logic [7:0] OP_BR_ZERO      = 8'h60;
    localparam logic [7:0] OP_CALL_FAR     = 8'h12;
    localparam logic [7:0] OP_JUMP_FAR     = 8'h02;
    localparam logic [7:0] OP_MOV_A_DIR    = 8'hE5;
    localparam logic [7:0] OP_MOV_A_IMM    = 8'hE4;
    localparam logic [7:0] OP_MOV_DIR_A    = 8'hF5;
    localparam logic [7:0] OP_MOV_DIR_DIR  = 8'h85;
    localparam logic [7:0] OP_MOV_DIR_IMM  = 8'h75;
    localparam logic [7:0] OP_MOV_C_BIT    = 8'hA2;
    localparam logic [7:0] OP_MOV_BIT_C    = 8'h92;
    localparam logic [7:0] OP_MOV_DP_IMM   = 8'h90;

    // ------------------------------------------------------------
    // Opcode groups: two-value groups match opcode[7:1]
    // ------------------------------------------------------------
    localparam logic [6:0] GP_MOV_A_IND    = 7'h73;
    localparam logic [6:0] GP_MOV_DIR_IND  = 7'h43;
    localparam logic [6:0] GP_MOV_IND_A    = 7'h7B;
    localparam logic [6:0] GP_MOV_IND_DIR  = 7'h53;
    localparam logic [6:0] GP_MOV_IND_IMM  = 7'h3B;

    // ------------------------------------------------------------
    // Opcode groups: eight-value groups match opcode[7:3]
    // ------------------------------------------------------------
    localparam logic [4:0] GB_MOV_A_RN     = 5'h1D;
    localparam logic [4:0] GB_MOV_RN_A     = 5'h1F;
    localparam logic [4:0] GB_MOV_RN_DIR   = 5'h15;
    localparam logic [4:0] GB_MOV_RN_IMM   = 5'h0F;
    localparam logic [4:0] GB_MOV_DIR_RN   = 5'h11;

    // ------------------------------------------------------------
    // Instruction lengths in bytes and cycle counts
    // ------------------------------------------------------------
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [2:0] CYC_1 = 3'h1;
    localparam logic [2:0] CYC_2 = 3'h2;
    localparam logic [2:0] CYC_3 = 3'h3;
    localparam logic [2:0] CYC_4 = 3'h4;
    localparam logic [2:0] CYC_5 = 3'h5;

    // ------------------------------------------------------------
    // Reset values and bit-address layout
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [7:0]  SP_RESET      = 8'h07;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [7:0]  BIT_AREA_BASE = 8'h20;
    localparam int          BIT_SFR_POS   = 7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;

    typedef struct packed {
        logic       legal;
        logic [1:0] len;
        logic [2:0] cyc;
    } decode_t;

endpackage

// ---- bank_file.sv ----
// Eight-entry bank register file with two read ports and one write port
`timescale 1ns/100ps
module bank_file
    import exec_pkg::*;
(
    input  wire logic       clk,      // Core clock
    input  wire logic       rst_n,    // Synchronous reset, active low
    input  wire logic       we,       // Write strobe
    input  wire logic [2:0] waddr,    // Write index
    input  wire logic [7:0] wdata,    // Write data
    input  wire logic [2:0] raddr_a,  // Read index, port a
    output logic      [7:0] rdata_a,  // Read data, port a
    input  wire logic       raddr_b,  // Pointer register select, port b
    output logic      [7:0] rdata_b   // Read data, port b
);

    typedef struct packed {
        logic [7:0][7:0] regs;
    } bank_state_t;

    bank_state_t s_reg;
    bank_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (we) begin
            s_next.regs[waddr] = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_a = s_reg.regs[raddr_a];
    assign rdata_b = s_reg.regs[{2'b00, raddr_b}];

endmodule

// ---- branch_move_exec.sv ----
// Execution unit for indirect/conditional/long jumps, long call and move instructions
// What this block does
// - Indirect jump loads PC with zero-extended A plus data pointer, sources unchanged.
// - Jump-if-bit-clear advances PC by three, adds displacement when bit is zero.
// - Jump-if-carry-clear advances PC by two, adds displacement only when carry zero.
// - Accumulator tests branch on nonzero or on zero, accumulator never changed.
// - Long call advances PC by three, pushes low then high, loads target.
// - Long jump loads PC high from byte two, low from byte three.
// - Opcodes E8 to EF copy the bank register into A in one cycle.
// - Direct-to-accumulator move copies the direct byte into A in two cycles.
// - Indirect-to-accumulator move reads the byte addressed by pointer register zero or one.
// - Immediate load places the second instruction byte into A.
// - Opcodes F8 to FF copy A into the bank register in one cycle.
// - Opcodes A8 to AF copy a direct byte into the bank register.
// - Opcodes 78 to 7F load the bank register with the second byte.
// - Accumulator-to-direct store writes A to the direct byte.
// - Opcodes 88 to 8F write the bank register to a direct byte.
// - Direct-to-direct move copies source byte into destination byte in three cycles.
// - Indirect-to-direct move copies the pointed byte into a direct byte.
// - Immediate store writes the third byte into the direct byte.
// - Indirect stores write A, a direct byte or immediate byte via pointer.
// - Bit-to-carry copies a bit into carry; carry-to-bit leaves flags alone.
// - Pointer load writes byte two to pointer high and byte three to low.
`timescale 1ns/100ps
module branch_move_exec
    import exec_pkg::*;
(
    input  wire logic        clk,                // Core clock, 100 MHz
    input  wire logic        rst_n,              // Synchronous reset, active low
    input  wire logic        start,              // Instruction presented this cycle
    input  wire logic [7:0]  opcode,             // First instruction byte
    input  wire logic [7:0]  operand_1,          // Second instruction byte
    input  wire logic [7:0]  operand_2,          // Third instruction byte
    input  wire logic [7:0]  mem_rdata,          // Internal data read return
    output logic      [7:0]  mem_addr,           // Internal data address
    output logic      [7:0]  mem_wdata,          // Internal data write value
    output logic             mem_we,             // Internal data write strobe
    output logic             mem_re,             // Internal data read strobe
    output logic      [15:0] program_counter,    // Program counter
    output logic      [7:0]  stack_pointer,      // Stack pointer
    output logic      [7:0]  work_register_a,    // Accumulator
    output logic      [7:0]  data_pointer_high,  // Data pointer high byte
    output logic      [7:0]  data_pointer_low,   // Data pointer low byte
    output logic             carry,              // Carry flag
    output logic             busy,               // Instruction in progress
    output logic             done,               // Instruction finished
    output logic             illegal             // Opcode not handled here
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        exec_state_t st;
        logic [2:0]  step;
        logic [2:0]  last;
        logic [1:0]  len;
        logic [7:0]  op;
        logic [7:0]  b2;
        logic [7:0]  b3;
        logic [7:0]  rdat;
        logic [15:0] pc;
        logic [7:0]  sp;
        logic [7:0]  acc;
        logic [7:0]  dp_hi;
        logic [7:0]  dp_lo;
        logic        cy;
        logic [7:0]  maddr;
        logic [7:0]  mwdata;
        logic        mwe;
        logic        mre;
        logic        busy;
        logic        done;
        logic        illegal;
    } exec_t;

    exec_t s_reg;
    exec_t s_next;

    logic       bank_we;
    logic [2:0] bank_wa;
    logic [7:0] bank_wd;
    logic [2:0] bank_ra;
    logic       bank_rb;
    logic [7:0] bank_rn;
    logic [7:0] bank_ri;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic decode_t decode(input logic [7:0] op);
        decode_t d;
        d = '{legal: 1'b1, len: LEN_1, cyc: CYC_1};
        if (op == OP_JMP_IND) d = '{1'b1, LEN_1, CYC_5};
        else if (op == OP_BR_BIT_CLR) d = '{1'b1, LEN_3, CYC_5};
        else if (op == OP_BR_CY_CLR) d = '{1'b1, LEN_2, CYC_3};
        else if (op == OP_BR_NONZERO || op == OP_BR_ZERO) d = '{1'b1, LEN_2, CYC_4};
        else if (op == OP_CALL_FAR || op == OP_JUMP_FAR) d = '{1'b1, LEN_3, CYC_4};
        else if (op == OP_MOV_A_DIR || op == OP_MOV_A_IMM) d = '{1'b1, LEN_2, CYC_2};
        else if (op == OP_MOV_DIR_A) d = '{1'b1, LEN_2, CYC_2};
        else if (op == OP_MOV_DIR_DIR) d = '{1'b1, LEN_3, CYC_3};
        else if (op == OP_MOV_DIR_IMM) d = '{1'b1, LEN_3, CYC_3};
        else if (op == OP_MOV_DP_IMM) d = '{1'b1, LEN_3, CYC_3};
        else if (op == OP_MOV_C_BIT) d = '{1'b1, LEN_2, CYC_2};
        else if (op == OP_MOV_BIT_C) d = '{1'b1, LEN_2, CYC_3};
        else if (op[7:1] == GP_MOV_A_IND) d = '{1'b1, LEN_1, CYC_2};
        else if (op[7:1] == GP_MOV_DIR_IND) d = '{1'b1, LEN_2, CYC_3};
        else if (op[7:1] == GP_MOV_IND_A) d = '{1'b1, LEN_1, CYC_2};
        else if (op[7:1] == GP_MOV_IND_DIR) d = '{1'b1, LEN_2, CYC_3};
        else if (op[7:1] == GP_MOV_IND_IMM) d = '{1'b1, LEN_2, CYC_2};
        else if (op[7:3] == GB_MOV_A_RN || op[7:3] == GB_MOV_RN_A) d = '{1'b1, LEN_1, CYC_1};
        else if (op[7:3] == GB_MOV_RN_DIR) d = '{1'b1, LEN_2, CYC_3};
        else if (op[7:3] == GB_MOV_RN_IMM) d = '{1'b1, LEN_2, CYC_2};
        else if (op[7:3] == GB_MOV_DIR_RN) d = '{1'b1, LEN_2, CYC_2};
        else d.legal = 1'b0;
        return d;
    endfunction

    // Byte holding an addressable bit: low area or an SFR row
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        logic [7:0] r;
        r = b[BIT_SFR_POS] ? {b[7:3], 3'b000} : BIT_AREA_BASE + {4'h0, b[6:3]};
        return r;
    endfunction

    function automatic logic [15:0] rel_add(input logic [15:0] pc, input logic [7:0] rel);
        logic [15:0] r;
        r = pc + {{8{rel[7]}}, rel};
        return r;
    endfunction

    // ------------------------------------------------------------
    // Bank registers
    // ------------------------------------------------------------
    bank_file u_bank (
        .clk     (clk),
        .rst_n   (rst_n),
        .we      (bank_we),
        .waddr   (bank_wa),
        .wdata   (bank_wd),
        .raddr_a (bank_ra),
        .rdata_a (bank_rn),
        .raddr_b (bank_rb),
        .rdata_b (bank_ri)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        decode_t     d;
        logic [7:0]  rd;
        logic [15:0] pc_seq;
        logic [15:0] ret;
        d      = decode(opcode);
        rd     = (s_reg.step == 3'h1) ? mem_rdata : s_reg.rdat;
        pc_seq = s_reg.pc + {14'h0000, s_reg.len};
        ret    = s_reg.pc + {14'h0000, LEN_3};
        s_next = s_reg;
        s_next.mwe  = 1'b0;
        s_next.mre  = 1'b0;
        s_next.done = 1'b0;
        bank_we = 1'b0;
        bank_wa = s_reg.op[2:0];
        bank_wd = s_reg.acc;
        bank_ra = (s_reg.st == ST_IDLE) ? opcode[2:0] : s_reg.op[2:0];
        bank_rb = (s_reg.st == ST_IDLE) ? opcode[0] : s_reg.op[0];
        unique case (s_reg.st)
            ST_IDLE: begin
                if (start) begin
                    s_next.st      = ST_EXEC;
                    s_next.op      = opcode;
                    s_next.b2      = operand_1;
                    s_next.b3      = operand_2;
                    s_next.step    = 3'h0;
                    s_next.last    = d.cyc - CYC_1;
                    s_next.len     = d.len;
                    s_next.busy    = 1'b1;
                    s_next.illegal = ~d.legal;
                    // First memory access is issued as the instruction is taken
                    if (opcode == OP_MOV_A_DIR || opcode == OP_MOV_DIR_DIR
                        || opcode[7:3] == GB_MOV_RN_DIR
                        || opcode[7:1] == GP_MOV_IND_DIR) begin
                        s_next.maddr = operand_1;
                        s_next.mre   = 1'b1;
                    end else if (opcode[7:1] == GP_MOV_A_IND
                                 || opcode[7:1] == GP_MOV_DIR_IND) begin
                        s_next.maddr = bank_ri;
                        s_next.mre   = 1'b1;
                    end else if (opcode == OP_BR_BIT_CLR || opcode == OP_MOV_C_BIT
                                 || opcode == OP_MOV_BIT_C) begin
                        s_next.maddr = bit_byte(operand_1);
                        s_next.mre   = 1'b1;
                    end else if (opcode == OP_MOV_DIR_A) begin
                        s_next.maddr  = operand_1;
                        s_next.mwdata = s_reg.acc;
                        s_next.mwe    = 1'b1;
                    end else if (opcode[7:3] == GB_MOV_DIR_RN) begin
                        s_next.maddr  = operand_1;
                        s_next.mwdata = bank_rn;
                        s_next.mwe    = 1'b1;
                    end else if (opcode == OP_MOV_DIR_IMM) begin
                        s_next.maddr  = operand_1;
                        s_next.mwdata = operand_2;
                        s_next.mwe    = 1'b1;
                    end else if (opcode[7:1] == GP_MOV_IND_A) begin
                        s_next.maddr  = bank_ri;
                        s_next.mwdata = s_reg.acc;
                        s_next.mwe    = 1'b1;
                    end else if (opcode[7:1] == GP_MOV_IND_IMM) begin
                        s_next.maddr  = bank_ri;
                        s_next.mwdata = operand_1;
                        s_next.mwe    = 1'b1;
                    end else if (opcode == OP_CALL_FAR) begin
                        s_next.maddr  = s_reg.sp + 8'h01;
                        s_next.mwdata = ret[7:0];
                        s_next.mwe    = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                if (s_reg.step == 3'h1) begin
                    s_next.rdat = mem_rdata;
                end
                // Second push of the long call
                if (s_reg.step == 3'h0 && s_reg.op == OP_CALL_FAR) begin
                    s_next.maddr  = s_reg.sp + 8'h02;
                    s_next.mwdata = ret[15:8];
                    s_next.mwe    = 1'b1;
                end
                // Write-back of bytes read at the start
                if (s_reg.step == 3'h1) begin
                    if (s_reg.op == OP_MOV_DIR_DIR) begin
                        s_next.maddr  = s_reg.b3;
                        s_next.mwdata = mem_rdata;
                        s_next.mwe    = 1'b1;
                    end else if (s_reg.op[7:1] == GP_MOV_DIR_IND) begin
                        s_next.maddr  = s_reg.b2;
                        s_next.mwdata = mem_rdata;
                        s_next.mwe    = 1'b1;
                    end else if (s_reg.op[7:1] == GP_MOV_IND_DIR) begin
                        s_next.maddr  = bank_ri;
                        s_next.mwdata = mem_rdata;
                        s_next.mwe    = 1'b1;
                    end else if (s_reg.op == OP_MOV_BIT_C) begin
                        s_next.mwdata = mem_rdata;
                        s_next.mwdata[s_reg.b2[2:0]] = s_reg.cy;
                        s_next.mwe    = 1'b1;
                    end
                end
                if (s_reg.step == s_reg.last) begin
                    s_next.st   = ST_IDLE;
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.pc   = pc_seq;
                    if (s_reg.op == OP_JMP_IND) begin
                        s_next.pc = {s_reg.dp_hi, s_reg.dp_lo} + {8'h00, s_reg.acc};
                    end else if (s_reg.op == OP_BR_BIT_CLR) begin
                        if (!rd[s_reg.b2[2:0]]) begin
                            s_next.pc = rel_add(pc_seq, s_reg.b3);
                        end
                    end else if (s_reg.op == OP_BR_CY_CLR) begin
                        if (!s_reg.cy) begin
                            s_next.pc = rel_add(pc_seq, s_reg.b2);
                        end
                    end else if (s_reg.op == OP_BR_NONZERO) begin
                        if (s_reg.acc != BYTE_RESET) begin
                            s_next.pc = rel_add(pc_seq, s_reg.b2);
                        end
                    end else if (s_reg.op == OP_BR_ZERO) begin
                        if (s_reg.acc == BYTE_RESET) begin
                            s_next.pc = rel_add(pc_seq, s_reg.b2);
                        end
                    end else if (s_reg.op == OP_CALL_FAR) begin
                        s_next.pc = {s_reg.b2, s_reg.b3};
                        s_next.sp = s_reg.sp + 8'h02;
                    end else if (s_reg.op == OP_JUMP_FAR) begin
                        s_next.pc = {s_reg.b2, s_reg.b3};
                    end else if (s_reg.op[7:3] == GB_MOV_A_RN) begin
                        s_next.acc = bank_rn;
                    end else if (s_reg.op == OP_MOV_A_DIR
                                 || s_reg.op[7:1] == GP_MOV_A_IND) begin
                        s_next.acc = rd;
                    end else if (s_reg.op == OP_MOV_A_IMM) begin
                        s_next.acc = s_reg.b2;
                    end else if (s_reg.op[7:3] == GB_MOV_RN_A) begin
                        bank_we = 1'b1;
                    end else if (s_reg.op[7:3] == GB_MOV_RN_DIR) begin
                        bank_we = 1'b1;
                        bank_wd = rd;
                    end else if (s_reg.op[7:3] == GB_MOV_RN_IMM) begin
                        bank_we = 1'b1;
                        bank_wd = s_reg.b2;
                    end else if (s_reg.op == OP_MOV_C_BIT) begin
                        s_next.cy = rd[s_reg.b2[2:0]];
                    end else if (s_reg.op == OP_MOV_DP_IMM) begin
                        s_next.dp_hi = s_reg.b2;
                        s_next.dp_lo = s_reg.b3;
                    end
                end else begin
                    s_next.step = s_reg.step + 3'h1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg     <= '0;
            s_reg.st  <= ST_IDLE;
            s_reg.pc  <= PC_RESET;
            s_reg.sp  <= SP_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mem_addr          = s_reg.maddr;
    assign mem_wdata         = s_reg.mwdata;
    assign mem_we            = s_reg.mwe;
    assign mem_re            = s_reg.mre;
    assign program_counter   = s_reg.pc;
    assign stack_pointer     = s_reg.sp;
    assign work_register_a   = s_reg.acc;
    assign data_pointer_high = s_reg.dp_hi;
    assign data_pointer_low  = s_reg.dp_lo;
    assign carry             = s_reg.cy;
    assign busy              = s_reg.busy;
    assign done              = s_reg.done;
    assign illegal           = s_reg.illegal;

endmodule

// ---- branch_move_exec_properties.sv ----
// Checker for the branch and move execution unit
`timescale 1ns/100ps
module branch_move_exec_properties
    import exec_pkg::*;
(
    input wire logic        clk,               // Core clock
    input wire logic        rst_n,             // Reset, active low
    input wire logic        start,             // Start request
    input wire logic [7:0]  opcode,            // First byte
    input wire logic [7:0]  operand_1,         // Second byte
    input wire logic [7:0]  operand_2,         // Third byte
    input wire logic [7:0]  mem_addr,          // Data address
    input wire logic        mem_we,            // Write strobe
    input wire logic        mem_re,            // Read strobe
    input wire logic [15:0] program_counter,   // Program counter
    input wire logic [7:0]  stack_pointer,     // Stack pointer
    input wire logic [7:0]  work_register_a,   // Accumulator
    input wire logic [7:0]  data_pointer_high, // Pointer high
    input wire logic [7:0]  data_pointer_low,  // Pointer low
    input wire logic        busy,              // Busy
    input wire logic        done               // Done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire        tk = start && !busy;
    logic [7:0] op_q, o1_q, o2_q, a_q, dh_q, dl_q, sp_q;
    logic [2:0] nb_q;
    // Snapshot at take, busy cycles counted until done
    always_ff @(posedge clk) begin
        if (tk) begin
            {op_q, o1_q, o2_q, a_q} <= {opcode, operand_1, operand_2, work_register_a};
            {dh_q, dl_q, sp_q, nb_q} <= {data_pointer_high, data_pointer_low, stack_pointer, 3'h0};
        end else if (busy) begin
            nb_q <= nb_q + 3'h1;
        end
    end
    ind_jump_a: assert property (done && op_q == OP_JMP_IND |-> nb_q == 3'h5 && work_register_a == a_q
        && program_counter == {dh_q, dl_q} + {8'h00, a_q}) else $error("indirect jump wrong");
    carry_jump_a: assert property (done && op_q == OP_BR_CY_CLR |-> nb_q == 3'h3)
        else $error("carry jump length wrong");
    bit_jump_a: assert property (done && op_q == OP_BR_BIT_CLR |-> nb_q == 3'h5)
        else $error("bit jump length wrong");
    acc_test_a: assert property (done && op_q == OP_BR_NONZERO |-> nb_q == 3'h4
        && work_register_a == a_q) else $error("accumulator test jump wrong");
    call_push_a: assert property (tk && opcode == OP_CALL_FAR |-> ##1 mem_we
        && mem_addr == stack_pointer + 8'h01 ##1 mem_we && mem_addr == $past(mem_addr) + 8'h01)
        else $error("call push order wrong");
    call_end_a: assert property (done && op_q == OP_CALL_FAR |->
        stack_pointer == sp_q + 8'h02 && program_counter == {o1_q, o2_q} && nb_q == 3'h4)
        else $error("call result wrong");
    long_jump_a: assert property (done && op_q == OP_JUMP_FAR |-> nb_q == 3'h4
        && program_counter == {o1_q, o2_q}) else $error("long jump wrong");
    imm_load_a: assert property (done && op_q == OP_MOV_A_IMM |-> work_register_a == o1_q)
        else $error("immediate load wrong");
    ptr_load_a: assert property (done && op_q == OP_MOV_DP_IMM
        |-> {data_pointer_high, data_pointer_low} == {o1_q, o2_q}) else $error("pointer load wrong");
    read_pulse_a: assert property (mem_re |=> !mem_re) else $error("read strobe too long");
endmodule
bind branch_move_exec branch_move_exec_properties chk_u (.clk, .rst_n, .start, .opcode,
    .operand_1, .operand_2, .mem_addr, .mem_we, .mem_re, .program_counter, .stack_pointer,
    .work_register_a, .data_pointer_high, .data_pointer_low, .busy, .done);

// ---- branch_move_exec_tb_top.sv ----
// Testbench for the branch and move execution unit
`timescale 1ns/100ps
module branch_move_exec_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, mem_we, mem_re, carry, busy, done, illegal;
    logic [7:0]  opcode = 8'h00, operand_1 = 8'h00, operand_2 = 8'h00, mem_rdata = 8'h00, rd_q;
    logic [7:0]  mem_addr, mem_wdata, stack_pointer, work_register_a, dh, dl;
    logic [7:0]  mem [256];
    logic [15:0] program_counter, pe = 16'h0000;
    int          err_count = 0, n_compared = 0;
    branch_move_exec dut_u (.clk, .rst_n, .start, .opcode, .operand_1, .operand_2, .mem_rdata,
        .mem_addr, .mem_wdata, .mem_we, .mem_re, .program_counter, .stack_pointer,
        .work_register_a, .data_pointer_high(dh), .data_pointer_low(dl), .carry, .busy, .done,
        .illegal);
    initial forever #5 clk = ~clk;
    // Internal data space with a read answer in the cycle after the strobe
    always @(posedge clk) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (mem_re) rd_q <= mem[mem_addr];
    end
    always @(negedge clk) mem_rdata <= rd_q;
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic run(input logic [7:0] op, b1, b2, input logic [15:0] len);
        int k;
        {opcode, operand_1, operand_2, start} = {op, b1, b2, 1'b1};
        @(negedge clk) start = 1'b0;
        for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge clk);
        chk("done", {15'h0000, done}, 16'h0001);
        pe = pe + len;
    endtask
    task automatic t_moves;
        run(8'hE4, 8'h55, 8'h00, 2); chk("acc imm", work_register_a, 8'h55);
        run(8'hF5, 8'h30, 8'h00, 2); chk("acc store", mem[8'h30], 8'h55);
        run(8'h7B, 8'hAA, 8'h00, 2); run(8'hEB, 8'h00, 8'h00, 1);
        chk("acc from bank", work_register_a, 8'hAA);
        run(8'h78, 8'h30, 8'h00, 2); run(8'hE6, 8'h00, 8'h00, 1);
        chk("acc indirect", work_register_a, 8'h55);
        run(8'h85, 8'h30, 8'h40, 3); chk("dir to dir", mem[8'h40], 8'h55);
        run(8'h75, 8'h41, 8'hC3, 3); run(8'hAC, 8'h41, 8'h00, 2); run(8'h8C, 8'h42, 8'h00, 2);
        chk("bank via dir", mem[8'h42], 8'hC3);
        run(8'hFD, 8'h00, 8'h00, 1); run(8'h8D, 8'h43, 8'h00, 2);
        chk("acc to bank", mem[8'h43], 8'h55);
        run(8'h76, 8'h66, 8'h00, 2); run(8'h86, 8'h44, 8'h00, 2);
        chk("indirect copy", mem[8'h44], 8'h66);
        run(8'hE5, 8'h42, 8'h00, 2); chk("acc direct", work_register_a, 8'hC3);
        chk("pc moves", program_counter, pe);
    endtask
    task automatic t_bits;
        run(8'h75, 8'h20, 8'h01, 3); run(8'hA2, 8'h00, 8'h00, 2);
        chk("bit to carry", {15'h0000, carry}, 16'h0001);
        run(8'h92, 8'h0F, 8'h00, 2); chk("carry to bit", mem[8'h21], 8'h80);
    endtask
    task automatic t_branch;
        run(8'h90, 8'h12, 8'hFF, 3); chk("ptr load", {dh, dl}, 16'h12FF);
        run(8'h73, 8'h00, 8'h00, 0); pe = 16'h13C2; chk("ind jump", program_counter, pe);
        run(8'h50, 8'h10, 8'h00, 2); chk("carry set", program_counter, pe);
        run(8'h30, 8'h08, 8'hFE, 1); chk("bit clear", program_counter, pe);
        run(8'h60, 8'h40, 8'h00, 2); run(8'h70, 8'h80, 8'h00, 2); pe = pe - 16'h0080;
        chk("acc jumps", program_counter, pe); chk("acc kept", work_register_a, 8'hC3);
        run(8'hA2, 8'h01, 8'h00, 2); run(8'h50, 8'h10, 8'h00, 18);
        chk("carry clear", program_counter, pe);
        run(8'h02, 8'hAB, 8'hCD, 0); chk("long jump", program_counter, 16'hABCD);
        run(8'h12, 8'h12, 8'h34, 0); chk("ret low", mem[8'h08], 8'hD0);
        chk("ret high", mem[8'h09], 8'hAB); chk("sp", stack_pointer, 8'h09);
        chk("call", program_counter, 16'h1234);
        run(8'hA5, 8'h00, 8'h00, 0); chk("refused", program_counter, 16'h1235);
        chk("illegal", {15'h0000, illegal}, 16'h0001);
    endtask
    task automatic end_of_test;
        if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000 err_count++;
        end_of_test;
    end
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_moves;
        t_bits;
        t_branch;
        end_of_test;
    end
endmodule
